// [verilog/stop_mode_wakeup_control.sv]
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
// Operation
// R1 - Port 2 bits set as outputs feed their inactive default into the NOR wake.
// R2 - Delay select bit 5: 0 skips stabilisation delay, 1 inserts it; resets 1.
// R3 - For fast wake, source must stay active at least five cpu clock periods.
// R4 - Software should keep delay enabled with crystal or resonator clocks.
// R5 - Level select bit 6: 1 wakes on high, 0 on low; resets 0.
// R6 - Read-only warm flag bit 7: 1 after stop wake, 0 after other reset.
// R7 - Port configuration register is write-only at offset zero.
// R8 - Port 3 mode register write-only at f7, kept across stop wake.
// R9 - Source select bits 4..2 pick reset, reserved, four pins or two NOR groups.
// R10 - Wake sources synchronised; warm flag set before execution resumes.
module stop_mode_wakeup_control #(
  parameter int stab_cycles = wake_pkg::stab_delay_cycles,
  parameter int fast_cycles = wake_pkg::fast_hold_cycles
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core handshake
  input wire logic stop_req_i,
  output logic stopped_o,
  output logic run_o,
  // Wake pins
  input wire logic [3:0] wake_pin_i,
  input wire logic [7:0] port2_pin_i,
  // Register contents to the ports
  output logic [7:0] port_configuration_o,
  output logic [7:0] port3_mode_o
);
  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  typedef enum logic [1:0] {st_run, st_stop, st_delay, st_fast} state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] portcfg_reg;
  logic [7:0] portcfg_next;
  logic [7:0] port3_reg;
  logic [7:0] port3_next;
  logic [7:0] p2dir_reg;
  logic [7:0] p2dir_next;
  logic warm_reg;
  logic warm_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;

  logic [3:0] pin_s;
  logic [7:0] p2_s;
  logic wake_cond;
  logic wr_go;
  logic rd_go;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  wake_sync #(.width(12)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({wake_pin_i, port2_pin_i}),
    .sync_o({pin_s, p2_s}) // R10
  );

  // Byte lane 0 merge
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel, input logic [31:0] d);
    lane0 = sel[0] ? d[7:0] : old;
  endfunction

  // ----------------------------------------
  // Wake source decode
  // ----------------------------------------
  function automatic logic pick(input logic [2:0] src, input logic [3:0] pins, input logic [7:0] p2,
                                input logic [7:0] dir, input logic hi);
    logic [7:0] act;
    act = '0;
    pick = 1'b0;
    // Output bits read as inactive so only true inputs wake
    for (int i = 0; i < 8; i++) begin
      act[i] = dir[i] ? 1'b0 : (p2[i] == hi); // R1 R5
    end
    unique case (src) // R9
      wake_pkg::src_reset_only: pick = 1'b0;
      wake_pkg::src_reserved: pick = 1'b0;
      wake_pkg::src_pin_a: pick = (pins[0] == hi);
      wake_pkg::src_pin_b: pick = (pins[1] == hi);
      wake_pkg::src_pin_c: pick = (pins[2] == hi);
      wake_pkg::src_pin_d: pick = (pins[3] == hi);
      wake_pkg::src_nor_low4: pick = |act[3:0];
      wake_pkg::src_nor_all8: pick = |act;
    endcase
  endfunction

  always_comb begin
    wake_cond = pick(ctrl_reg[wake_pkg::src_hi_bit:wake_pkg::src_lo_bit], pin_s, p2_s, p2dir_reg,
                     ctrl_reg[wake_pkg::level_sel_bit]);
  end

  // ----------------------------------------
  // Bus and registers
  // ----------------------------------------
  // Single-wait-state slave: ack one cycle after strobe, then drops
  // Writes land on the ack edge, while the master still holds its request
  assign wr_go = cyc_i && stb_i && ack_reg && we_i;
  assign rd_go = cyc_i && stb_i && !ack_reg && !we_i;

  always_comb begin
    ctrl_next = ctrl_reg;
    portcfg_next = portcfg_reg;
    port3_next = port3_reg;
    p2dir_next = p2dir_reg;
    ack_next = cyc_i && stb_i && !ack_reg;
    rdat_next = rdat_reg;
    if (wr_go) begin
      unique case (adr_i)
        wake_pkg::port_configuration_addr: portcfg_next = lane0(portcfg_reg, sel_i, dat_i); // R7
        wake_pkg::port3_mode_addr: port3_next = lane0(port3_reg, sel_i, dat_i); // R8
        wake_pkg::wake_recovery_control_addr: ctrl_next = lane0(ctrl_reg, sel_i, dat_i);
        wake_pkg::port2_direction_addr: p2dir_next = lane0(p2dir_reg, sel_i, dat_i);
        default: ;
      endcase
    end
    if (rd_go) begin
      rdat_next = 32'h0000_0000;
      // Write-only registers read as zero
      unique case (adr_i)
        wake_pkg::wake_recovery_control_addr: rdat_next = {24'h00_0000, warm_reg, ctrl_reg[6:0]}; // R6
        wake_pkg::port2_direction_addr: rdat_next = {24'h00_0000, p2dir_reg};
        wake_pkg::wake_status_addr: rdat_next = {30'h0, state_reg};
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Stop and recovery sequence
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    warm_next = warm_reg;
    unique case (state_reg)
      st_run: begin
        if (stop_req_i) begin
          state_next = st_stop;
        end
      end
      st_stop: begin
        cnt_next = 32'h0000_0000;
        if (wake_cond) begin
          // Fast wake still checks the source holds for its minimum
          state_next = ctrl_reg[wake_pkg::delay_sel_bit] ? st_delay : st_fast; // R2
        end
      end
      st_delay: begin
        cnt_next = cnt_reg + 32'h0000_0001;
        if (cnt_reg >= 32'(stab_cycles - 1)) begin // R2 R4
          state_next = st_run;
          warm_next = 1'b1; // R6 R10
        end
      end
      st_fast: begin
        cnt_next = cnt_reg + 32'h0000_0001;
        if (!wake_cond) begin
          state_next = st_stop; // R3
        end else if (cnt_reg >= 32'(fast_cycles - 2)) begin
          state_next = st_run;
          warm_next = 1'b1; // R6
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= st_run;
      cnt_reg <= 32'h0000_0000;
      warm_reg <= 1'b0; // R6
      ctrl_reg <= wake_pkg::wake_recovery_control_rst; // R2 R5
      portcfg_reg <= wake_pkg::port_configuration_rst;
      port3_reg <= wake_pkg::port3_mode_rst; // R8
      p2dir_reg <= wake_pkg::port2_direction_rst;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      warm_reg <= warm_next;
      ctrl_reg <= ctrl_next;
      portcfg_reg <= portcfg_next;
      port3_reg <= port3_next;
      p2dir_reg <= p2dir_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;
  assign stopped_o = (state_reg == st_stop);
  assign run_o = (state_reg == st_run);
  assign port_configuration_o = portcfg_reg;
  assign port3_mode_o = port3_reg;
endmodule

// [include/wake_pkg.sv]
package wake_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] port_configuration_addr = 8'h00;
  localparam logic [7:0] port3_mode_addr = 8'hf7;
  localparam logic [7:0] wake_recovery_control_addr = 8'h0c;
  localparam logic [7:0] port2_direction_addr = 8'h10;
  localparam logic [7:0] wake_status_addr = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int src_lo_bit = 2;
  localparam int src_hi_bit = 4;
  localparam int delay_sel_bit = 5;
  localparam int level_sel_bit = 6;
  localparam int warm_bit = 7;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] wake_recovery_control_rst = 8'h20;
  localparam logic [7:0] port_configuration_rst = 8'h00;
  localparam logic [7:0] port3_mode_rst = 8'h00;
  localparam logic [7:0] port2_direction_rst = 8'h00;
  // ----------------------------------------
  // Source select codes
  // ----------------------------------------
  localparam logic [2:0] src_reset_only = 3'h0;
  localparam logic [2:0] src_reserved = 3'h1;
  localparam logic [2:0] src_pin_a = 3'h2;
  localparam logic [2:0] src_pin_b = 3'h3;
  localparam logic [2:0] src_pin_c = 3'h4;
  localparam logic [2:0] src_pin_d = 3'h5;
  localparam logic [2:0] src_nor_low4 = 3'h6;
  localparam logic [2:0] src_nor_all8 = 3'h7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int clk_hz = 50000000;
  localparam int stab_delay_us = 1000;
  localparam int stab_delay_cycles = stab_delay_us * (clk_hz / 1000000);
  localparam int fast_hold_cycles = 5;
endpackage

// [verilog/wake_sync.sv]
`timescale 1ns/1ns
module wake_sync #(
  parameter int width = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] sync_o
);
  logic [width-1:0] first_reg;
  logic [width-1:0] first_next;
  logic [width-1:0] second_reg;
  logic [width-1:0] second_next;

  always_comb begin
    first_next = async_i;
    second_next = first_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg <= '0;
      second_reg <= '0;
    end else begin
      first_reg <= first_next;
      second_reg <= second_next;
    end
  end

  assign sync_o = second_reg;
endmodule

// [tb/wake_src_model.sv]
`timescale 1ns/1ns
module wake_src_model (
  // Control from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic lvl_i,
  input wire logic [11:0] mask_i,
  input wire logic [7:0] hold_i,
  // Board pins
  output logic [3:0] wake_pin_o,
  output logic [7:0] port2_pin_o
);
  logic [7:0] left;
  initial left = 8'h00;
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= hold_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Idle pins sit at the inactive level, never floating
  assign {port2_pin_o, wake_pin_o} = ((left != 8'h00) ? mask_i : 12'h000) ^ {12{~lvl_i}};
endmodule

// [tb/wake_props.sv]
`timescale 1ns/1ns
module wake_props #(
  parameter int stab_cycles = wake_pkg::stab_delay_cycles,
  parameter int fast_cycles = wake_pkg::fast_hold_cycles
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Sequence and pins
  input wire logic stopped_o,
  input wire logic run_o,
  input wire logic [3:0] wake_pin_i,
  input wire logic [7:0] port2_pin_i,
  // Register contents
  input wire logic [7:0] port_configuration_o,
  input wire logic [7:0] port3_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Shadow config, written on the ack edge as in the design
  // ----------------------------------------
  logic [7:0] cfg_q, dir_q, p;
  logic [15:0] cnt_q;
  logic run_q, woke_q, act;
  always_comb begin
    p = (port2_pin_i ^ {8{~cfg_q[6]}}) & ~dir_q;
    case (cfg_q[4:2])
      3'h2, 3'h3, 3'h4, 3'h5: act = wake_pin_i[cfg_q[3:2] - 2'h2] == cfg_q[6];
      3'h6: act = |p[3:0];
      3'h7: act = |p;
      default: act = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 8'h20;
      dir_q <= 8'h00;
    end else if (ack_o && we_i && sel_i[0] && adr_i == 8'h0c) begin
      cfg_q <= dat_i[7:0];
    end else if (ack_o && we_i && sel_i[0] && adr_i == 8'h10) begin
      dir_q <= dat_i[7:0];
    end
    cnt_q <= (rst_i || run_o || stopped_o) ? 16'h0000 : cnt_q + 16'h0001;
    run_q <= rst_i | run_o;
    woke_q <= !rst_i && (woke_q || (run_o && !run_q));
  end
  sequence held_s;
    stopped_o && act ##1 act ##1 act;
  endsequence
  wo_read_a: assert property (cyc_i && stb_i && !we_i && !ack_o && (adr_i == 8'h00 || adr_i == 8'hf7)
    |=> ack_o && dat_o == 32'h0) else $error("write-only register read not zero");
  p3_keep_a: assert property ($changed(port3_mode_o) |-> $past(cyc_i && stb_i && we_i && adr_i == 8'hf7))
    else $error("port3 mode changed without a write");
  pcfg_keep_a: assert property ($changed(port_configuration_o) |-> $past(cyc_i && stb_i && we_i && adr_i == 8'h00))
    else $error("port configuration changed without a write");
  stay_asleep_a: assert property (stopped_o && !act && !$past(act) && !$past(act, 2) |=> stopped_o)
    else $error("left stop with no active source");
  wake_sync_a: assert property (held_s |-> ##[0:3] !stopped_o)
    else $error("held source did not wake");
  delay_len_a: assert property ($rose(run_o) && cfg_q[5] |-> cnt_q >= stab_cycles - 1 && cnt_q <= stab_cycles + 2)
    else $error("stabilisation delay length wrong");
  fast_len_a: assert property ($rose(run_o) && !cfg_q[5] |-> cnt_q >= fast_cycles - 1 && cnt_q <= fast_cycles + 2)
    else $error("fast wake check length wrong");
  warm_flag_a: assert property (ack_o && !we_i && adr_i == 8'h0c |-> dat_o[7] == woke_q)
    else $error("warm flag wrong");
endmodule
bind stop_mode_wakeup_control wake_props #(
  .stab_cycles(stab_cycles),
  .fast_cycles(fast_cycles)
) u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .stopped_o(stopped_o),
  .run_o(run_o),
  .wake_pin_i(wake_pin_i),
  .port2_pin_i(port2_pin_i),
  .port_configuration_o(port_configuration_o),
  .port3_mode_o(port3_mode_o)
);

// [tb/tb_stop_mode_wakeup_control.sv]
`timescale 1ns/1ns
module tb_stop_mode_wakeup_control;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, stop_req_i, go, lvl, ack_o, stopped_o, run_o;
  logic [3:0] sel_i, wake_pin_i;
  logic [7:0] adr_i, port2_pin_i, pcfg, port3, rd, hold;
  logic [11:0] mask;
  logic [31:0] dat_i, dat_o;
  int fails, tests_run;
  stop_mode_wakeup_control #(.stab_cycles(8), .fast_cycles(5)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .stop_req_i, .stopped_o, .run_o, .wake_pin_i, .port2_pin_i,
    .port_configuration_o(pcfg), .port3_mode_o(port3));
  wake_src_model u_src (.clk_i, .go_i(go), .lvl_i(lvl), .mask_i(mask), .hold_i(hold),
    .wake_pin_o(wake_pin_i), .port2_pin_o(port2_pin_i));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    fails++;
    end_sim;
  end
  task end_sim;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task t_wake(input logic [7:0] cfg, input logic [7:0] dir, input logic [11:0] m, input logic [7:0] h, input logic e);
    int i;
    lvl <= cfg[6];
    mask <= m;
    hold <= h;
    wb(1, 8'h0c, cfg);
    wb(1, 8'h10, dir);
    if (run_o === 1'b1) begin
      stop_req_i <= 1;
      @(posedge clk_i);
      stop_req_i <= 0;
      @(posedge clk_i);
    end
    chk("stopped", 8'h01, {7'h0, stopped_o});
    wb(0, 8'h14, 8'h00);
    chk("state_stop", 8'h01, rd);
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    for (i = 0; i < 40 && run_o !== 1'b1; i++) @(posedge clk_i);
    chk("run", {7'h0, e}, {7'h0, run_o});
    wb(0, 8'h0c, 8'h00);
    if (e) chk("warm", {1'b1, cfg[6:0]}, rd);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    wb(0, 8'h0c, 8'h00);
    chk("ctrl_rst", 8'h20, rd);
    wb(1, 8'h00, 8'h5a);
    chk("pcfg", 8'h5a, pcfg);
    sel_i <= 4'h0;
    wb(1, 8'h00, 8'hff);
    sel_i <= 4'h1;
    chk("pcfg_sel_off", 8'h5a, pcfg);
    wb(1, 8'h10, 8'h3c);
    wb(0, 8'h10, 8'h00);
    chk("dir_rd", 8'h3c, rd);
    wb(0, 8'h00, 8'h00);
    chk("pcfg_rd", 8'h00, rd);
    wb(1, 8'hf7, 8'ha5);
    wb(0, 8'hf7, 8'h00);
    chk("port3_rd", 8'h00, rd);
    wb(1, 8'h40, 8'hff);
    wb(0, 8'h40, 8'h00);
    chk("unmapped", 8'h00, rd);
  endtask
  task t_codes;
    for (int c = 2; c < 8; c++) begin
      // Delay bit left on for most codes, as for crystal clocks
      t_wake({1'b0, c[0], c[1], c[2:0], 2'b00}, 8'h00,
        c < 6 ? 12'h001 << (c - 2) : (c == 6 ? 12'h010 : 12'h800), 8'h10, 1);
      chk("port3_kept", 8'ha5, port3);
    end
  endtask
  task t_mask_fast;
    t_wake(8'h18, 8'h01, 12'h010, 8'h10, 0);
    t_wake(8'h18, 8'h01, 12'h020, 8'h10, 1);
    t_wake(8'h08, 8'h00, 12'h001, 8'h02, 0);
    t_wake(8'h08, 8'h00, 12'h001, 8'h10, 1);
  endtask
  task t_cold;
    t_wake(8'h00, 8'h00, 12'hfff, 8'h10, 0);
    t_wake(8'h04, 8'h00, 12'hfff, 8'h10, 0);
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h0c, 8'h00);
    chk("cold", 8'h20, rd);
    chk("port3_cold", 8'h00, port3);
  endtask
  initial begin
    {rst_i, sel_i} = 5'h11;
    {cyc_i, stb_i, we_i, stop_req_i, go, lvl, adr_i, dat_i, mask, hold} = '0;
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs;
    t_codes;
    t_mask_fast;
    t_cold;
    end_sim;
  end
endmodule
